/* rtl/wdog_defs.svh */
// Offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
`define ADDR_WDOG_CTRL      8'hD8
`define ADDR_IRQ_ENABLE     8'hE8
`define ADDR_IRQ_PRIORITY   8'hF8
`define ADDR_WDOG_STATUS    8'hD9
`define ADDR_WDOG_MASK      8'hDA
`define BIT_RESTART         0
`define BIT_RESET_ENABLE    1
`define BIT_RESET_CAUSE     2
`define BIT_TIMEOUT_FLAG    3
`define BIT_CLOCK_SELECT    4
`define BIT_POWER_ON        6
`define BIT_WDOG_IRQ_EN     5
`define IRQ_REG_MASK        8'h3F
`define IRQ_REG_RESET       8'h00
`define CTRL_WRITE_MASK     8'h1B
`define WDOG_TIMEOUT_CYCLES 20'h1_0000
`define WDOG_RESET_DELAY    10'h200
`define EV_TIMEOUT          0
`define EV_WDOG_RESET       1
`endif

/* rtl/wdog_pkg.sv */
// Types shared by the watchdog control block.
// Assumes the defines header sits beside it.
package wdog_pkg;
	typedef enum logic [1:0] {
		ST_COUNT,
		ST_GRACE,
		ST_FIRED
	} wdog_state_t;

	typedef struct packed {
		wdog_state_t  state;
		logic [19:0]  count;
		logic [9:0]   grace;
		logic         power_on;
		logic         clock_select;
		logic         timeout_flag;
		logic         reset_cause;
		logic         reset_enable;
		logic         restart;
		logic [7:0]   irq_enable;
		logic [7:0]   irq_priority;
		logic [1:0]   ev_status;
		logic [1:0]   ev_mask;
		logic [7:0]   rdata;
		logic         sys_reset;
		logic         wdog_irq_req;
		logic         wdog_irq_high;
		logic         ev_irq;
		logic         prev_sub_clk;
	} wdog_regs_t;
endpackage

/* rtl/wdog_ctrl.sv */
// Watchdog control, reset cause flags and extended interrupt bits.
// Assumes a plain register port, one clock, and reset kinds given as strobes.
//
// Overview of operation
// - Power-on flag set by power-up, cleared only by software write.
// - Counter ticks on sub clock edge if select is one, else main clock.
// - Timeout flag set each time the counter reaches its timeout with no reset in the same cycle.
// - Watchdog request needs flag, enable, global enable and other conditions.
// - Timeout flag cleared by software writing zero or by any reset.
// - Reset cause flag set on watchdog reset, held until software or a power-fail or power-on reset clears it.
// - Reset cause flag cleared by power-fail or power-on reset.
// - With reset enable zero, the watchdog never touches the cause flag.
// - Watchdog system reset only while reset enable is one.
// - Writing one to restart reloads counter; restart bit clears itself.
// - System reset 512 clocks after timeout when enabled and not restarted.
// - External reset loads control pattern, keeping cause flag and unchanged bits.
// - Reset enable cleared on power-on reset only.
// - Enable register holds six source enables, top two bits reserved.
// - Priority bit zero means low priority, one means high priority.
// - Enable and priority registers reset to zero on power-on, external, watchdog reset.
`timescale 1ns/1ps
`include "wdog_defs.svh"
module wdog_ctrl #(
	parameter logic [19:0] TIMEOUT_CYCLES = `WDOG_TIMEOUT_CYCLES
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_por_rst,
	input  wire logic       i_ext_rst,
	input  wire logic       i_pfail_rst,
	input  wire logic       i_sub_clk,
	input  wire logic       i_global_irq_en,
	input  wire logic       i_irq_other_ok,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_wdog_sys_reset,
	output logic            o_wdog_irq_req,
	output logic            o_wdog_irq_high,
	output logic            o_irq
);
	// ******************************************************
	// State
	// ******************************************************
	wdog_pkg::wdog_regs_t r_r;
	wdog_pkg::wdog_regs_t r_nxt;

	function automatic logic [7:0] ctrl_word(input wdog_pkg::wdog_regs_t s);
		logic [7:0] w;
		w = 8'h00;
		w[`BIT_POWER_ON]     = s.power_on;
		w[`BIT_CLOCK_SELECT] = s.clock_select;
		w[`BIT_TIMEOUT_FLAG] = s.timeout_flag;
		w[`BIT_RESET_CAUSE]  = s.reset_cause;
		w[`BIT_RESET_ENABLE] = s.reset_enable;
		w[`BIT_RESTART]      = s.restart;
		return w;
	endfunction

	logic tick;
	logic wr_ctrl;
	logic hit_timeout;
	logic any_reset;
	logic [1:0] ev_set;

	// ******************************************************
	// Next state
	// ******************************************************
	always_comb begin
		r_nxt       = r_r;
		r_nxt.prev_sub_clk = i_sub_clk;
		tick        = r_r.clock_select ? (i_sub_clk & ~r_r.prev_sub_clk) : 1'b1;
		wr_ctrl     = i_wr && (i_addr == `ADDR_WDOG_CTRL);
		hit_timeout = tick && (r_r.state == wdog_pkg::ST_COUNT)
		              && (r_r.count == TIMEOUT_CYCLES - 20'h0_0001);
		any_reset   = i_por_rst | i_ext_rst | i_pfail_rst | r_r.sys_reset;
		ev_set      = 2'b00;
		r_nxt.restart   = 1'b0;
		r_nxt.sys_reset = 1'b0;

		// Counter and grace window
		case (r_r.state)
			wdog_pkg::ST_COUNT: begin
				if (tick) begin
					r_nxt.count = r_r.count + 20'h0_0001;
				end
				if (hit_timeout) begin
					r_nxt.count = 20'h0_0000;
					r_nxt.grace = 10'h000;
					r_nxt.state = wdog_pkg::ST_GRACE;
				end
			end
			wdog_pkg::ST_GRACE: begin
				// Grace counts core clocks regardless of the counter source
				r_nxt.grace = r_r.grace + 10'h001;
				if (r_r.grace == `WDOG_RESET_DELAY - 10'h001) begin
					if (r_r.reset_enable) begin
						r_nxt.sys_reset = 1'b1;
						r_nxt.state     = wdog_pkg::ST_FIRED;
					end else begin
						r_nxt.state = wdog_pkg::ST_COUNT;
					end
				end
			end
			wdog_pkg::ST_FIRED: begin
				r_nxt.state = wdog_pkg::ST_COUNT;
			end
			default: begin
				r_nxt.state = wdog_pkg::ST_COUNT;
			end
		endcase
		if (hit_timeout) begin
			ev_set[`EV_TIMEOUT] = 1'b1;
		end

		// Register writes
		if (wr_ctrl) begin
			r_nxt.clock_select = i_wdata[`BIT_CLOCK_SELECT];
			r_nxt.reset_enable = i_wdata[`BIT_RESET_ENABLE];
			if (!i_wdata[`BIT_POWER_ON]) begin
				r_nxt.power_on = 1'b0;
			end
			if (!i_wdata[`BIT_TIMEOUT_FLAG]) begin
				r_nxt.timeout_flag = 1'b0;
			end
			if (!i_wdata[`BIT_RESET_CAUSE]) begin
				r_nxt.reset_cause = 1'b0;
			end
			if (i_wdata[`BIT_RESTART]) begin
				r_nxt.restart = 1'b1;
				r_nxt.count   = 20'h0_0000;
				r_nxt.grace   = 10'h000;
				r_nxt.state   = wdog_pkg::ST_COUNT;
			end
		end
		if (i_wr && (i_addr == `ADDR_IRQ_ENABLE)) begin
			r_nxt.irq_enable = i_wdata & `IRQ_REG_MASK;
		end
		if (i_wr && (i_addr == `ADDR_IRQ_PRIORITY)) begin
			r_nxt.irq_priority = i_wdata & `IRQ_REG_MASK;
		end
		if (i_wr && (i_addr == `ADDR_WDOG_STATUS)) begin
			r_nxt.ev_status = r_r.ev_status & ~i_wdata[1:0];
		end
		if (i_wr && (i_addr == `ADDR_WDOG_MASK)) begin
			r_nxt.ev_mask = i_wdata[1:0];
		end

		// Hardware set wins over software clear
		if (hit_timeout) begin
			r_nxt.timeout_flag = 1'b1;
		end
		if (r_r.sys_reset && r_r.reset_enable) begin
			r_nxt.reset_cause = 1'b1;
			ev_set[`EV_WDOG_RESET] = 1'b1;
		end
		r_nxt.ev_status = r_nxt.ev_status | ev_set;

		// Reset kinds; watchdog reset arrives as sys_reset one cycle later
		if (any_reset) begin
			r_nxt.timeout_flag = 1'b0;
			r_nxt.irq_enable   = `IRQ_REG_RESET;
			r_nxt.irq_priority = `IRQ_REG_RESET;
			r_nxt.restart      = 1'b0;
			r_nxt.count        = 20'h0_0000;
			r_nxt.grace        = 10'h000;
			r_nxt.state        = wdog_pkg::ST_COUNT;
			r_nxt.clock_select = 1'b0;
		end
		// External reset leaves power_on, cause and reset enable alone
		if (i_pfail_rst) begin
			r_nxt.reset_cause = 1'b0;
		end
		if (i_por_rst) begin
			r_nxt.power_on     = 1'b1;
			r_nxt.reset_cause  = 1'b0;
			r_nxt.reset_enable = 1'b0;
		end

		// Interrupt outputs
		r_nxt.wdog_irq_req  = r_nxt.timeout_flag && r_nxt.irq_enable[`BIT_WDOG_IRQ_EN]
		                      && i_global_irq_en && i_irq_other_ok;
		r_nxt.wdog_irq_high = r_nxt.irq_priority[`BIT_WDOG_IRQ_EN];
		r_nxt.ev_irq        = |(r_nxt.ev_status & r_nxt.ev_mask);

		// Read data, one cycle later
		r_nxt.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`ADDR_WDOG_CTRL:    r_nxt.rdata = ctrl_word(r_r);
				`ADDR_IRQ_ENABLE:   r_nxt.rdata = r_r.irq_enable;
				`ADDR_IRQ_PRIORITY: r_nxt.rdata = r_r.irq_priority;
				`ADDR_WDOG_STATUS:  r_nxt.rdata = {6'h00, r_r.ev_status};
				`ADDR_WDOG_MASK:    r_nxt.rdata = {6'h00, r_r.ev_mask};
				default:            r_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ******************************************************
	// Registers
	// ******************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			r_r              <= '0;
			r_r.power_on     <= 1'b1;
			r_r.state        <= wdog_pkg::ST_COUNT;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_rdata          = r_r.rdata;
	assign o_wdog_sys_reset = r_r.sys_reset;
	assign o_wdog_irq_req   = r_r.wdog_irq_req;
	assign o_wdog_irq_high  = r_r.wdog_irq_high;
	assign o_irq            = r_r.ev_irq;

	// ******************************************************
	// Checks
	// ******************************************************
	property p_timeout_sets_flag;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(hit_timeout && !any_reset) |=> r_r.timeout_flag;
	endproperty
	a_timeout_sets_flag: assert property (p_timeout_sets_flag)
		else $error("timeout did not set flag");

	property p_restart_self_clears;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(r_r.restart && !(wr_ctrl && i_wdata[`BIT_RESTART])) |=> !r_r.restart;
	endproperty
	a_restart_self_clears: assert property (p_restart_self_clears)
		else $error("restart bit stuck");

	property p_reset_only_enabled;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(r_r.sys_reset) |-> $past(r_r.reset_enable);
	endproperty
	a_reset_only_enabled: assert property (p_reset_only_enabled)
		else $error("watchdog reset while disabled");

	property p_reset_delay;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(hit_timeout && r_r.reset_enable && !any_reset && !wr_ctrl)
		##1 (!wr_ctrl && !any_reset && r_r.reset_enable) [*8]
		|-> (r_r.state == wdog_pkg::ST_GRACE) && !r_r.sys_reset;
	endproperty
	a_reset_delay: assert property (p_reset_delay)
		else $error("reset before delay elapsed");

	property p_por_clears_enable;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_por_rst |=> !r_r.reset_enable && r_r.power_on && !r_r.reset_cause;
	endproperty
	a_por_clears_enable: assert property (p_por_clears_enable)
		else $error("power-on reset state wrong");

	property p_pfail_clears_cause;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_pfail_rst |=> !r_r.reset_cause;
	endproperty
	a_pfail_clears_cause: assert property (p_pfail_clears_cause)
		else $error("cause flag not cleared");

	property p_ext_keeps_cause;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_ext_rst && !i_por_rst && !i_pfail_rst && !wr_ctrl && !r_r.sys_reset)
		|=> (r_r.reset_cause == $past(r_r.reset_cause))
		    && (r_r.power_on == $past(r_r.power_on));
	endproperty
	a_ext_keeps_cause: assert property (p_ext_keeps_cause)
		else $error("external reset changed cause flag");

	property p_irq_regs_reset;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		any_reset |=> (r_r.irq_enable == 8'h00) && (r_r.irq_priority == 8'h00)
		              && !r_r.timeout_flag;
	endproperty
	a_irq_regs_reset: assert property (p_irq_regs_reset)
		else $error("enable or priority not reset");

	property p_irq_request;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_wdog_irq_req |-> r_r.timeout_flag && r_r.irq_enable[`BIT_WDOG_IRQ_EN];
	endproperty
	a_irq_request: assert property (p_irq_request)
		else $error("request without cause");

	property p_power_on_sticky;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$fell(r_r.power_on) |-> $past(wr_ctrl) && !$past(i_wdata[`BIT_POWER_ON]);
	endproperty
	a_power_on_sticky: assert property (p_power_on_sticky)
		else $error("power-on flag cleared without write");

	property p_sub_clock_hold;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(r_r.clock_select && (r_r.state == wdog_pkg::ST_COUNT) && !wr_ctrl && !any_reset
		 && !(i_sub_clk && !r_r.prev_sub_clk)) |=> $stable(r_r.count);
	endproperty
	a_sub_clock_hold: assert property (p_sub_clock_hold)
		else $error("counter moved without sub clock edge");

	property p_flag_write_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(wr_ctrl && !i_wdata[`BIT_TIMEOUT_FLAG] && !hit_timeout) |=> !r_r.timeout_flag;
	endproperty
	a_flag_write_clear: assert property (p_flag_write_clear)
		else $error("timeout flag not cleared by write");

	property p_cause_set;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(r_r.sys_reset && r_r.reset_enable && !i_pfail_rst && !i_por_rst) |=> r_r.reset_cause;
	endproperty
	a_cause_set: assert property (p_cause_set)
		else $error("cause flag not set by watchdog reset");

	property p_cause_untouched;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!r_r.reset_enable && !r_r.reset_cause) |=> !r_r.reset_cause;
	endproperty
	a_cause_untouched: assert property (p_cause_untouched)
		else $error("cause flag set while reset disabled");

	property p_sys_reset_pulse;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		r_r.sys_reset |=> !r_r.sys_reset;
	endproperty
	a_sys_reset_pulse: assert property (p_sys_reset_pulse)
		else $error("system reset longer than one cycle");

	property p_irq_reserved;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(r_r.irq_enable[7:6] == 2'b00) && (r_r.irq_priority[7:6] == 2'b00);
	endproperty
	a_irq_reserved: assert property (p_irq_reserved)
		else $error("reserved interrupt bits set");

	c_timeout: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) hit_timeout);
	c_sys_reset: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(r_r.sys_reset));
	c_restart: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(r_r.state == wdog_pkg::ST_GRACE) && wr_ctrl && i_wdata[`BIT_RESTART]);
endmodule // wdog_ctrl

/* dv/tb_wdog_ctrl.sv */
// Self-checking bench for the watchdog control block, driven over its register port.
// Assumes the design's defines header is on the include path and its assertions are built in.
`timescale 1ns/1ps
`include "wdog_defs.svh"
module tb_wdog_ctrl;
	// ****************************************
	// Signals
	// ****************************************
	localparam logic [19:0] TMO = 20'h0_0010;
	logic       i_ref_clk;
	logic       i_sys_rst;
	logic       i_por_rst;
	logic       i_ext_rst;
	logic       i_pfail_rst;
	logic       i_sub_clk;
	logic       i_global_irq_en;
	logic       i_irq_other_ok;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata;
	logic       o_wdog_sys_reset;
	logic       o_wdog_irq_req;
	logic       o_wdog_irq_high;
	logic       o_irq;
	int         num_errors;
	int         n_tests;
	int         n;
	logic [7:0] sr_cnt;

	// Short timeout so the grace window dominates the run
	wdog_ctrl #(.TIMEOUT_CYCLES(TMO)) DUT (
		.i_ref_clk       (i_ref_clk),
		.i_sys_rst       (i_sys_rst),
		.i_por_rst       (i_por_rst),
		.i_ext_rst       (i_ext_rst),
		.i_pfail_rst     (i_pfail_rst),
		.i_sub_clk       (i_sub_clk),
		.i_global_irq_en (i_global_irq_en),
		.i_irq_other_ok  (i_irq_other_ok),
		.i_addr          (i_addr),
		.i_wdata         (i_wdata),
		.i_wr            (i_wr),
		.i_rd            (i_rd),
		.o_rdata         (o_rdata),
		.o_wdog_sys_reset(o_wdog_sys_reset),
		.o_wdog_irq_req  (o_wdog_irq_req),
		.o_wdog_irq_high (o_wdog_irq_high),
		.o_irq           (o_irq)
	);

	// ****************************************
	// Clock, reset pulse count, watchdog
	// ****************************************
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		if (o_wdog_sys_reset === 1'b1) sr_cnt <= sr_cnt + 8'h01;
	end
	// Run needs about 1600 cycles
	initial begin
		#100000;
		num_errors++;
		$display("unexpected at %0t: run hung", $time);
		report_and_stop();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic report_and_stop();
		$display("errors %0d, compares %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	// Order is por, ext, pfail
	task automatic kind(input logic [2:0] k);
		@(posedge i_ref_clk);
		{i_por_rst, i_ext_rst, i_pfail_rst} <= k;
		@(posedge i_ref_clk);
		{i_por_rst, i_ext_rst, i_pfail_rst} <= 3'b000;
		cyc(3);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{i_por_rst, i_ext_rst, i_pfail_rst, i_sub_clk, i_wr, i_rd} = 6'b00_0000;
		{i_global_irq_en, i_irq_other_ok, i_addr, i_wdata} = 18'h1_0000;
		i_irq_other_ok = 1'b1;
		i_sys_rst = 1'b1;
		num_errors = 0;
		n_tests = 0;
		sr_cnt = 8'h00;
		repeat (8) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		rd(`ADDR_WDOG_CTRL, 8'h40);
		rd(`ADDR_IRQ_ENABLE, 8'h00);
		rd(`ADDR_IRQ_PRIORITY, 8'h00);
		rd(8'h55, 8'h00);
		wr(`ADDR_IRQ_ENABLE, 8'hFF);
		rd(`ADDR_IRQ_ENABLE, 8'h3F);
		wr(`ADDR_IRQ_PRIORITY, 8'hFF);
		rd(`ADDR_IRQ_PRIORITY, 8'h3F);
		chk({7'h00, o_wdog_irq_high}, 8'h01);
		// Timeout without reset enable, global enable low first
		wr(`ADDR_WDOG_CTRL, 8'h01);
		rd(`ADDR_WDOG_CTRL, 8'h00);
		cyc(25);
		rd(`ADDR_WDOG_CTRL, 8'h08);
		chk({7'h00, o_wdog_irq_req}, 8'h00);
		i_global_irq_en <= 1'b1;
		cyc(3);
		chk({7'h00, o_wdog_irq_req}, 8'h01);
		rd(`ADDR_WDOG_STATUS, 8'h01);
		wr(`ADDR_WDOG_MASK, 8'h01);
		cyc(3);
		chk({7'h00, o_irq}, 8'h01);
		wr(`ADDR_WDOG_MASK, 8'h00);
		cyc(3);
		chk({7'h00, o_irq}, 8'h00);
		cyc(600);
		chk(sr_cnt, 8'h00);
		wr(`ADDR_WDOG_CTRL, 8'h01);
		rd(`ADDR_WDOG_CTRL, 8'h00);
		wr(`ADDR_WDOG_STATUS, 8'h03);
		wr(`ADDR_WDOG_MASK, 8'h01);
		cyc(3);
		chk({7'h00, o_irq}, 8'h00);
		// Restarts keep the flag bit, so only a timeout could set it
		for (n = 0; n < 6; n++) begin
			wr(`ADDR_WDOG_CTRL, 8'h09);
			cyc(10);
		end
		rd(`ADDR_WDOG_CTRL, 8'h00);
		chk({7'h00, o_irq}, 8'h00);
		// Sub clock selected and held still, then 16 slow ticks
		wr(`ADDR_WDOG_CTRL, 8'h11);
		cyc(100);
		rd(`ADDR_WDOG_CTRL, 8'h10);
		for (n = 0; n < 16; n++) begin
			@(posedge i_ref_clk);
			i_sub_clk <= 1'b1;
			cyc(4);
			i_sub_clk <= 1'b0;
			cyc(4);
		end
		rd(`ADDR_WDOG_CTRL, 8'h18);
		// Watchdog reset 512 clocks after the timeout
		wr(`ADDR_IRQ_ENABLE, 8'h20);
		wr(`ADDR_IRQ_PRIORITY, 8'h20);
		wr(`ADDR_WDOG_CTRL, 8'h03);
		cyc(3);
		n = 0;
		while (o_wdog_irq_req !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk({7'h00, o_wdog_irq_high}, 8'h01);
		n = 0;
		while (o_wdog_sys_reset !== 1'b1 && n < 700) begin
			cyc(1);
			n++;
		end
		chk({7'h00, (n == 512)}, 8'h01);
		cyc(3);
		chk(sr_cnt, 8'h01);
		rd(`ADDR_WDOG_CTRL, 8'h06);
		rd(`ADDR_IRQ_ENABLE, 8'h00);
		rd(`ADDR_IRQ_PRIORITY, 8'h00);
		// Reset kinds
		wr(`ADDR_WDOG_CTRL, 8'h16);
		wr(`ADDR_IRQ_ENABLE, 8'h01);
		kind(3'b010);
		rd(`ADDR_WDOG_CTRL, 8'h06);
		rd(`ADDR_IRQ_ENABLE, 8'h00);
		kind(3'b001);
		rd(`ADDR_WDOG_CTRL, 8'h02);
		kind(3'b100);
		rd(`ADDR_WDOG_CTRL, 8'h40);
		chk({7'h00, o_wdog_irq_req}, 8'h00);
		kind(3'b010);
		rd(`ADDR_WDOG_CTRL, 8'h40);
		report_and_stop();
	end
endmodule // tb_wdog_ctrl
